/* File: verilog/cfg_loader_params.svh */
// Constants for the volatile configuration word loader.
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH
`define CFG_FLASH_AW        24
`define CFG_FLASH_DW        24
`define CFG_FLASH_TOP_ADDR  24'h00_57FE
`define CFG_SHADOW_BASE     24'hF8_0000
`define CFG_SPACE_BASE      24'h80_0000
`define CFG_SHADOW_WORDS    4
`define CFG_ERASED_BYTE     8'hFF
`define CFG_FLASH_LAT       2
`endif

/* File: verilog/cfg_loader_pkg.sv */
// Types for the volatile configuration word loader.
package cfg_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ0  = 3'b001,
        ST_WAIT0 = 3'b010,
        ST_REQ1  = 3'b011,
        ST_WAIT1 = 3'b100,
        ST_DONE  = 3'b101
    } load_state_type;
endpackage : cfg_loader_pkg

/* File: verilog/cfg_unpack.sv */
// Spreads two packed flash configuration words across the shadow registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_params.svh"
module cfg_unpack (
    input  wire logic [23:0] i_word0,
    input  wire logic [23:0] i_word1,
    output logic      [95:0] o_shadow
);
    // Low 16 bits of each word carry configuration; upper bytes are unimplemented.
    always_comb begin
        o_shadow        = {96{1'b1}};
        o_shadow[7:0]   = i_word0[7:0];
        o_shadow[31:24] = i_word0[15:8];
        o_shadow[55:48] = i_word1[7:0];
        o_shadow[87:80] = i_word1[15:8];
    end
endmodule : cfg_unpack
`default_nettype wire

/* File: verilog/cfg_loader.sv */
// Loads the flash configuration words into volatile shadow registers on every reset.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_params.svh"
// Summary of operation
// - Shadow bits read 0 when programmed, 1 when erased.
// - Shadow bits are read-only, mapped from configuration address F80000.
// - Configuration space readable only by table reads, never by fetch.
// - Shadow registers are volatile and must be reloaded after power-up.
// - Source data are the two highest words of program flash.
// - Packed words are unpacked into scattered shadow locations.
// - Copy happens automatically on reset without software.
// - Every reset source triggers a reload.
// - Unimplemented word bits have no effect when written with ones.
// - Erasing the last page sets words to all ones, leaving code protection off.
// - Serial programming through any of three clock and data pin pairs.
module cfg_loader #(
    parameter int FLASH_LAT = `CFG_FLASH_LAT
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_dev_reset,
    output logic             o_flash_rd,
    output logic [23:0]      o_flash_addr,
    input  wire logic [23:0] i_flash_rdata,
    input  wire logic        i_tbl_rd,
    input  wire logic        i_ifetch,
    input  wire logic [23:0] i_cpu_addr,
    output logic [23:0]      o_tbl_rdata,
    output logic             o_tbl_hit,
    output logic             o_core_rst,
    output logic             o_cfg_valid,
    output logic             o_code_protect,
    output logic [95:0]      o_cfg_shadow,
    input  wire logic [2:0]  i_prog_sel,
    input  wire logic [2:0]  i_prog_serial_clock_pin,
    input  wire logic [2:0]  i_prog_serial_data_pin_in,
    input  wire logic        i_prog_data_out,
    input  wire logic        i_prog_data_oe,
    output logic [2:0]       o_prog_serial_data_pin_out,
    output logic [2:0]       o_prog_serial_data_pin_oe,
    output logic             o_prog_clk,
    output logic             o_prog_data
);
    // Sequencer state, latency count and the two captured flash words.
    cfg_loader_pkg::load_state_type state_r;
    cfg_loader_pkg::load_state_type state_nxt;
    logic [1:0]                     lat_r;
    logic [1:0]                     lat_nxt;
    logic [23:0]                    word0_r;
    logic [23:0]                    word0_nxt;
    logic [23:0]                    word1_r;
    logic [23:0]                    word1_nxt;
    logic                           valid_r;
    logic                           valid_nxt;
    // Registered shadow image, protection flag and the unpacked next image.
    logic [95:0]                    shadow_r;
    logic [95:0]                    shadow_nxt;
    logic                           protect_r;
    logic                           protect_nxt;
    logic [95:0]                    unpacked;
    // Table-read answer registers.
    logic [23:0]                    rdata_r;
    logic [23:0]                    rdata_nxt;
    logic                           hit_r;
    logic                           hit_nxt;

    // The unpacker works on the next word values so the shadow image is ready on the same edge.
    cfg_unpack u_unpack (
        .i_word0  (word0_nxt),
        .i_word1  (word1_nxt),
        .o_shadow (unpacked)
    );

    // Load sequencer: reads the top two flash words after every reset.
    // A device reset in mid-load restarts from the first word, so no half-loaded image survives.
    always_comb begin
        state_nxt  = state_r;
        lat_nxt    = lat_r;
        word0_nxt  = word0_r;
        word1_nxt  = word1_r;
        valid_nxt  = valid_r;
        o_flash_rd = 1'b0;
        o_flash_addr = `CFG_FLASH_TOP_ADDR;
        if (i_dev_reset) begin
            state_nxt = cfg_loader_pkg::ST_IDLE;
            valid_nxt = 1'b0;
            word0_nxt = {24{1'b1}};
            word1_nxt = {24{1'b1}};
        end else begin
            unique case (state_r)
                cfg_loader_pkg::ST_IDLE: begin
                    state_nxt = cfg_loader_pkg::ST_REQ0;
                end
                cfg_loader_pkg::ST_REQ0: begin
                    o_flash_rd   = 1'b1;
                    o_flash_addr = `CFG_FLASH_TOP_ADDR;
                    lat_nxt      = 2'(FLASH_LAT - 1);
                    state_nxt    = cfg_loader_pkg::ST_WAIT0;
                end
                cfg_loader_pkg::ST_WAIT0: begin
                    if (lat_r == 2'd0) begin
                        word0_nxt = i_flash_rdata;
                        state_nxt = cfg_loader_pkg::ST_REQ1;
                    end else begin
                        lat_nxt = lat_r - 2'd1;
                    end
                end
                cfg_loader_pkg::ST_REQ1: begin
                    o_flash_rd   = 1'b1;
                    o_flash_addr = `CFG_FLASH_TOP_ADDR + 24'h00_0002;
                    lat_nxt      = 2'(FLASH_LAT - 1);
                    state_nxt    = cfg_loader_pkg::ST_WAIT1;
                end
                cfg_loader_pkg::ST_WAIT1: begin
                    if (lat_r == 2'd0) begin
                        word1_nxt = i_flash_rdata;
                        valid_nxt = 1'b1;
                        state_nxt = cfg_loader_pkg::ST_DONE;
                    end else begin
                        lat_nxt = lat_r - 2'd1;
                    end
                end
                cfg_loader_pkg::ST_DONE: begin
                    state_nxt = cfg_loader_pkg::ST_DONE;
                end
                default: begin
                    state_nxt = cfg_loader_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Loader state registers; the words read erased (all ones) until loaded, which is
    // also what a blank flash would give.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= cfg_loader_pkg::ST_IDLE;
            lat_r   <= 2'd0;
            word0_r <= {24{1'b1}};
            word1_r <= {24{1'b1}};
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            lat_r   <= lat_nxt;
            word0_r <= word0_nxt;
            word1_r <= word1_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Shadow and protection follow the words being captured, so they change on the
    // same edge as the valid flag and never lag it by a cycle.
    always_comb begin
        shadow_nxt  = {96{1'b1}};
        protect_nxt = 1'b0;
        if (valid_nxt) begin
            shadow_nxt  = unpacked;
            protect_nxt = !unpacked[0];
        end
    end

    // Shadow and protection registers; erased and unprotected out of reset.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            shadow_r  <= {96{1'b1}};
            protect_r <= 1'b0;
        end else begin
            shadow_r  <= shadow_nxt;
            protect_r <= protect_nxt;
        end
    end

    // Table-read path into configuration space; fetches never hit.
    // Addresses above the shadow bytes still hit but return zero.
    always_comb begin
        hit_nxt   = 1'b0;
        rdata_nxt = 24'h00_0000;
        if (i_tbl_rd && !i_ifetch && i_cpu_addr >= `CFG_SPACE_BASE) begin
            hit_nxt = 1'b1;
            if (i_cpu_addr >= `CFG_SHADOW_BASE && i_cpu_addr < `CFG_SHADOW_BASE + 24'(2 * `CFG_SHADOW_WORDS)) begin
                // Each of the low four shadow bytes occupies one even address; unprogrammed reads 1.
                rdata_nxt = {16'h0000, shadow_r[8 * i_cpu_addr[2:1] +: 8]};
            end
        end
    end

    // Read data register; no write path exists into shadow bits.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 24'h00_0000;
            hit_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            hit_r   <= hit_nxt;
        end
    end

    // The shadow, status and table-read outputs come from registers; o_flash_rd, o_flash_addr and the programming outputs are combinational.
    assign o_cfg_shadow   = shadow_r;
    assign o_cfg_valid    = valid_r;
    // The core stays in reset until both words are in place.
    assign o_core_rst     = !valid_r;
    // Erased all-ones words after a last-page erase leave code protection off.
    assign o_code_protect = protect_r;
    assign o_tbl_rdata    = rdata_r;
    assign o_tbl_hit      = hit_r;

    // Programming pin pair selection: one of three pairs carries the link.
    // Only the selected pair is ever driven, so the other pins stay free for general use.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            assign o_prog_serial_data_pin_out[g] = i_prog_data_out;
            assign o_prog_serial_data_pin_oe[g]  = i_prog_data_oe && i_prog_sel[g];
        end
    endgenerate
    // The selected pair's clock and data reach the programming logic; the others are ignored.
    assign o_prog_clk  = |(i_prog_serial_clock_pin & i_prog_sel);
    assign o_prog_data = |(i_prog_serial_data_pin_in & i_prog_sel);
endmodule : cfg_loader
`default_nettype wire

/* File: test/flash_model.sv */
// Behavioural flash array that answers the loader's word reads.
`timescale 1ns/1ps
`default_nettype none
module flash_model #(parameter int LAT = 2) (
    input  wire logic        i_mclk,
    input  wire logic        i_rd,
    input  wire logic [23:0] i_addr,
    input  wire logic [23:0] i_w0,
    input  wire logic [23:0] i_w1,
    output logic      [23:0] o_rdata
);
    logic [23:0] d_r [LAT];
    logic        v_r [LAT];
    logic [23:0] junk_r = 24'h5A_A5A5;
    // The two top words answer LAT cycles after the read; the junk pattern flips every cycle.
    always_ff @(posedge i_mclk) begin
        junk_r <= ~junk_r;
        d_r[0] <= (i_addr == 24'h00_57FE) ? i_w0 : ((i_addr == 24'h00_5800) ? i_w1 : junk_r);
        v_r[0] <= i_rd;
        for (int k = 1; k < LAT; k++) begin
            d_r[k] <= d_r[k-1];
            v_r[k] <= v_r[k-1];
        end
    end
    // Outside its answer cycle the bus never shows the last word.
    assign o_rdata = v_r[LAT-1] ? d_r[LAT-1] : junk_r;
endmodule : flash_model
`default_nettype wire

/* File: test/cfg_loader_monitor.sv */
// Port checker for the configuration word loader.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_monitor (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_dev_reset,
    input wire logic        i_tbl_rd,
    input wire logic        i_ifetch,
    input wire logic [23:0] i_cpu_addr,
    input wire logic [23:0] o_flash_addr,
    input wire logic [23:0] o_tbl_rdata,
    input wire logic        o_flash_rd,
    input wire logic        o_tbl_hit,
    input wire logic        o_core_rst,
    input wire logic        o_cfg_valid,
    input wire logic        o_code_protect,
    input wire logic [95:0] o_cfg_shadow
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_rst_hold; o_core_rst == !o_cfg_valid; endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("core reset wrong");
    property p_erased; !o_cfg_valid |-> &o_cfg_shadow; endproperty
    a_erased: assert property (p_erased) else $error("shadow not erased");
    property p_src; $fell(i_dev_reset) |-> ##[0:3] (o_flash_rd && o_flash_addr == 24'h00_57FE); endproperty
    a_src: assert property (p_src) else $error("first read wrong");
    property p_auto; $fell(i_dev_reset) |-> !o_cfg_valid [*3] ##[1:10] o_cfg_valid; endproperty
    a_auto: assert property (p_auto) else $error("load not done");
    property p_reload; i_dev_reset |=> o_core_rst && !o_cfg_valid; endproperty
    a_reload: assert property (p_reload) else $error("reset kept config");
    property p_keep; o_cfg_valid && !i_dev_reset |=> o_cfg_valid && $stable(o_cfg_shadow); endproperty
    a_keep: assert property (p_keep) else $error("shadow changed");
    property p_miss; i_ifetch || (i_tbl_rd && i_cpu_addr < 24'h80_0000) |=> !o_tbl_hit; endproperty
    a_miss: assert property (p_miss) else $error("bad access hit");
    property p_hit; i_tbl_rd && !i_ifetch && i_cpu_addr[23] && !i_dev_reset |=> o_tbl_hit; endproperty
    a_hit: assert property (p_hit) else $error("table read missed");
    property p_base;
        i_tbl_rd && !i_ifetch && i_cpu_addr == 24'hF8_0000 && !i_dev_reset
            |=> o_tbl_rdata == {16'h0000, $past(o_cfg_shadow[7:0])};
    endproperty
    a_base: assert property (p_base) else $error("base byte wrong");
    property p_protect; o_code_protect == !o_cfg_shadow[0]; endproperty
    a_protect: assert property (p_protect) else $error("protect wrong");
endmodule : cfg_loader_monitor
bind cfg_loader cfg_loader_monitor cfg_loader_monitor_inst (.i_mclk, .i_rst, .i_dev_reset, .i_tbl_rd,
    .i_ifetch, .i_cpu_addr, .o_flash_addr, .o_tbl_rdata, .o_flash_rd, .o_tbl_hit, .o_core_rst,
    .o_cfg_valid, .o_code_protect, .o_cfg_shadow);
`default_nettype wire

/* File: test/cfg_loader_tb_top.sv */
// Self-checking bench for the configuration word loader.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_tb_top;
    logic        i_mclk = 0, i_rst = 1, i_dev_reset = 0, i_tbl_rd = 0, i_ifetch = 0;
    logic        i_prog_data_out = 0, i_prog_data_oe = 0, o_flash_rd, o_tbl_hit, o_core_rst, o_cfg_valid;
    logic        o_code_protect, o_prog_clk, o_prog_data;
    logic [23:0] i_cpu_addr = 0, w0 = 0, w1 = 0, i_flash_rdata, o_flash_addr, o_tbl_rdata;
    logic [2:0]  i_prog_sel = 1, i_prog_serial_clock_pin = 0, i_prog_serial_data_pin_in = 0;
    logic [2:0]  o_prog_serial_data_pin_out, o_prog_serial_data_pin_oe;
    logic [95:0] o_cfg_shadow;
    int          error_cnt = 0, compares = 0;
    // Free-running clock of 8 ns.
    always #4 i_mclk = ~i_mclk;
    cfg_loader #(.FLASH_LAT(2)) cfg_loader_inst (.*);
    flash_model #(.LAT(2)) flash_model_inst (.i_mclk, .i_rd(o_flash_rd), .i_addr(o_flash_addr),
        .i_w0(w0), .i_w1(w1), .o_rdata(i_flash_rdata));
    task automatic chk(input string nm, input logic [95:0] exp, got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic load_test(input logic [23:0] a, b);
        logic [95:0] e;
        int          n;
        e = {8'hFF, b[15:8], 24'hFF_FFFF, b[7:0], 16'hFFFF, a[15:8], 16'hFFFF, a[7:0]};
        @(posedge i_mclk);
        w0 <= a;
        w1 <= b;
        i_dev_reset <= 1;
        @(posedge i_mclk);
        i_dev_reset <= 0;
        #1 chk("erased", '1, o_cfg_shadow);
        for (n = 0; n < 20 && !o_cfg_valid; n++) begin
            @(posedge i_mclk);
            #1;
        end
        chk("load_cycles", 96'(3 + 2 * 2), 96'(n));
        chk("valid", 1, o_cfg_valid);
        chk("shadow", e, o_cfg_shadow);
        chk("protect", !e[0], o_code_protect);
        chk("core_rst", 0, o_core_rst);
    endtask : load_test
    // Mid-run asynchronous reset: the shadow goes erased, then reloads by itself.
    task automatic rst_test(input logic [95:0] e);
        @(posedge i_mclk);
        i_rst <= 1;
        @(posedge i_mclk);
        #1 chk("rst_shadow", '1, o_cfg_shadow);
        chk("rst_core_rst", 1, o_core_rst);
        @(posedge i_mclk);
        i_rst <= 0;
        for (int n = 0; n < 20 && !o_cfg_valid; n++) begin
            @(posedge i_mclk);
            #1;
        end
        chk("reload", e, o_cfg_shadow);
    endtask : rst_test
    task automatic tbl(input logic [23:0] ad, input logic f, h, input logic [7:0] d);
        @(posedge i_mclk);
        i_tbl_rd <= 1;
        i_ifetch <= f;
        i_cpu_addr <= ad;
        @(posedge i_mclk);
        i_tbl_rd <= 0;
        i_ifetch <= 0;
        #1 chk("hit", h, o_tbl_hit);
        if (h) chk("rdata", d, o_tbl_rdata);
    endtask : tbl
    task automatic final_report;
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // Main sequence.
    initial begin
        repeat (9) @(posedge i_mclk);
        #1 chk("reset_shadow", 96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF, o_cfg_shadow);
        chk("reset_core_rst", 1, o_core_rst);
        @(posedge i_mclk);
        i_rst <= 0;
        load_test(24'hFF_FFFF, 24'hFF_FFFF);
        load_test(24'h00_1234, 24'h00_5678);
        load_test(24'h00_0000, 24'h00_0000);
        load_test(24'hFF_C380, 24'hFF_7E42);
        load_test(24'hFF_C381, 24'hFF_7E42);
        tbl(24'hF8_0000, 0, 1, 8'h81);
        tbl(24'hF8_0006, 0, 1, 8'hC3);
        tbl(24'hF8_0008, 0, 1, 8'h00);
        tbl(24'hF8_0000, 1, 0, 0);
        tbl(24'h00_57FE, 0, 0, 0);
        rst_test(96'hFF7E_FFFF_FF42_FFFF_C3FF_FF81);
        for (int s = 0; s < 3; s++) begin
            @(posedge i_mclk);
            i_prog_sel <= 3'(1 << s);
            i_prog_serial_clock_pin <= 3'(1 << s);
            i_prog_serial_data_pin_in <= ~3'(1 << s);
            i_prog_data_out <= 1;
            i_prog_data_oe <= 1;
            @(posedge i_mclk);
            #1 chk("prog", {2'b10, 3'(1 << s), 3'(1 << s)}, {o_prog_clk, o_prog_data, o_prog_serial_data_pin_oe,
                o_prog_serial_data_pin_out & o_prog_serial_data_pin_oe});
            @(posedge i_mclk);
            i_prog_serial_data_pin_in <= 3'(1 << s);
            i_prog_data_oe <= 0;
            @(posedge i_mclk);
            #1 chk("prog_idle", {1'b1, 3'b000}, {o_prog_data, o_prog_serial_data_pin_oe});
        end
        final_report;
    end
    // Watchdog far beyond the expected run of under a hundred cycles.
    initial begin
        #20000;
        error_cnt++;
        final_report;
    end
endmodule : cfg_loader_tb_top
`default_nettype wire
